// File: hw/ifec_top.v
// Purpose: Interrupt control register two and three flag status banks
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Enables gate flags onto the request outputs to the CPU
//
// Function
// [R1] Select bit fifteen picks alternate vector table
// [R2] Bit fourteen read-only, shows timed disable state
// [R3] Polarity bit one falling edge, zero rising
// [R4] Implemented bits reset zero; unimplemented read zero
// [R5] Flags read/write, hardware sets on request
// [R6] Bank zero layout: ADC down to pin0
// [R7] Bank one layout: UART2 down to I2C1 slave
// [R8] Bank two layout: parallel port, compares, captures, SPI2
// [R9] Pin flags set on selected edge
// [R10] Software clears flags; hardware only sets
// [R11] Per-source enable gates request forwarding
// [R12] Write one sets; hardware set beats clear
`timescale 1ns/100ps
`include "ifec_consts.vh"

module ifec_top (
  input wire i_clk_sys,
  input wire i_rst_n,
  // Register port
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [15:0] o_rdata,
  // Timed interrupt-disable state from the CPU
  input wire i_timed_irq_disable_active,
  // External interrupt pins 4 to 0
  input wire [4:0] i_ext_pin,
  // Peripheral request pulses, bank 0
  input wire i_adc_done,
  input wire i_uart1_tx,
  input wire i_uart1_rx,
  input wire i_spi1_event,
  input wire i_spi1_fault,
  input wire i_timer3,
  input wire i_timer2,
  input wire i_compare2,
  input wire i_capture2,
  input wire i_timer1,
  input wire i_compare1,
  input wire i_capture1,
  // Peripheral request pulses, bank 1
  input wire i_uart2_tx,
  input wire i_uart2_rx,
  input wire i_timer5,
  input wire i_timer4,
  input wire i_compare4,
  input wire i_compare3,
  input wire i_capture8,
  input wire i_capture7,
  input wire i_change_notify,
  input wire i_comparator,
  input wire i_i2c1_master,
  input wire i_i2c1_slave,
  // Peripheral request pulses, bank 2
  input wire i_parallel_port,
  input wire [3:0] i_compare8_5,
  input wire [3:0] i_capture6_3,
  input wire i_spi2_event,
  input wire i_spi2_fault,
  // Outputs toward the CPU and other banks
  output reg o_alt_vector_table_select,
  output reg [4:0] o_ext_edge,
  output reg [15:0] o_req_bank0,
  output reg [15:0] o_req_bank1,
  output reg [15:0] o_req_bank2,
  output reg o_irq
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  // Decode a strobe against one register index
  function hit;
    input [3:0] addr;
    input [3:0] ofs;
    input strobe;
    begin
      hit = strobe && (addr == ofs);
    end
  endfunction

  // Edge of the selected polarity between two samples
  function edge_seen;
    input prev;
    input cur;
    input pol;
    begin
      if (pol) begin
        edge_seen = prev & ~cur; // Falling edge
      end else begin
        edge_seen = ~prev & cur; // Rising edge
      end
    end
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  reg alt_vt_r;
  reg timed_dis_r;
  reg [4:0] pol_r;
  reg [4:0] pin_prev_r;
  reg primed_r;
  reg [15:0] enable0_r;
  reg [15:0] enable1_r;
  reg [15:0] enable2_r;
  reg [3:0] irq_status_r;
  reg [3:0] irq_mask_r;
  reg [3:0] irq_status_nxt;
  reg [15:0] rdata_nxt;
  wire [4:0] edge_det;
  wire [15:0] set0;
  wire [15:0] set1;
  wire [15:0] set2;
  wire [15:0] flags0;
  wire [15:0] flags1;
  wire [15:0] flags2;
  wire [15:0] new0;
  wire [15:0] new1;
  wire [15:0] new2;
  wire wr_ctrl2;
  wire wr_en0;
  wire wr_en1;
  wire wr_en2;
  wire wr_mask;
  wire rd_status;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  assign wr_ctrl2 = hit(i_addr, `IFEC_OFS_CTRL2, i_wr);
  assign wr_en0 = hit(i_addr, `IFEC_OFS_ENABLE0, i_wr);
  assign wr_en1 = hit(i_addr, `IFEC_OFS_ENABLE1, i_wr);
  assign wr_en2 = hit(i_addr, `IFEC_OFS_ENABLE2, i_wr);
  assign wr_mask = hit(i_addr, `IFEC_OFS_IRQ_MASK, i_wr);
  assign rd_status = hit(i_addr, `IFEC_OFS_IRQ_STATUS, i_rd);

  // ****************************************************************
  // Control register two
  // ****************************************************************
  // Vector table select and edge polarities are software written;
  // the disable bit follows the CPU and ignores writes
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_vt_r <= 1'b0; // [R4]
      pol_r <= 5'h00; // [R4]
      timed_dis_r <= 1'b0; // [R4]
    end else begin
      if (wr_ctrl2) begin
        alt_vt_r <= i_wdata[`IFEC_BIT_ALT_VT];
        pol_r <= i_wdata[`IFEC_POL_MSB:`IFEC_POL_LSB]; // [R3]
      end
      timed_dis_r <= i_timed_irq_disable_active; // [R2]
    end
  end

  // Table select drives the vector fetch logic
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_alt_vector_table_select <= 1'b0;
    end else begin
      o_alt_vector_table_select <= wr_ctrl2 ?
        i_wdata[`IFEC_BIT_ALT_VT] : alt_vt_r; // [R1]
    end
  end

  // ****************************************************************
  // External pin edge detection
  // ****************************************************************
  // Previous pin samples; primed_r blocks a false edge at the
  // first sample after reset, when pin_prev_r is not yet real
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_prev_r <= 5'h00;
      primed_r <= 1'b0;
    end else begin
      pin_prev_r <= i_ext_pin;
      primed_r <= 1'b1;
    end
  end

  // One detector per pin, each with its own polarity
  genvar gi;
  generate
    for (gi = 0; gi < `IFEC_NUM_EXT; gi = gi + 1) begin : g_edge
      assign edge_det[gi] = primed_r &
        edge_seen(pin_prev_r[gi], i_ext_pin[gi], pol_r[gi]); // [R3]
    end
  endgenerate

  // Edge pulses for all five pins, registered one cycle after detection
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ext_edge <= 5'h00;
    end else begin
      o_ext_edge <= edge_det; // [R9]
    end
  end

  // ****************************************************************
  // Hardware set vectors
  // ****************************************************************
  // Bank zero: ADC at 13 down to pin 0 at 0, bit 4 empty
  assign set0 = {2'b00, i_adc_done, i_uart1_tx, i_uart1_rx,
    i_spi1_event, i_spi1_fault, i_timer3, i_timer2, i_compare2,
    i_capture2, 1'b0, i_timer1, i_compare1, i_capture1,
    edge_det[0]}; // [R6] [R9]

  // Bank one: UART2 at 15 down to I2C1 slave, bits 8 and 5 empty
  assign set1 = {i_uart2_tx, i_uart2_rx, edge_det[2], i_timer5,
    i_timer4, i_compare4, i_compare3, 1'b0, i_capture8, i_capture7,
    1'b0, edge_det[1], i_change_notify, i_comparator, i_i2c1_master,
    i_i2c1_slave}; // [R7] [R9]

  // Bank two: parallel port at 13, compares 8..5, captures 6..3
  assign set2 = {2'b00, i_parallel_port, i_compare8_5, i_capture6_3,
    3'b000, i_spi2_event, i_spi2_fault}; // [R8]

  // ****************************************************************
  // Flag banks
  // ****************************************************************
  ifec_flag_bank #(
    .IMPL(`IFEC_BANK0_IMPL)
  ) u_bank0 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr(hit(i_addr, `IFEC_OFS_FLAGS0, i_wr)),
    .i_wdata(i_wdata),
    .i_set(set0),
    .o_flags(flags0),
    .o_new(new0)
  );

  ifec_flag_bank #(
    .IMPL(`IFEC_BANK1_IMPL)
  ) u_bank1 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr(hit(i_addr, `IFEC_OFS_FLAGS1, i_wr)),
    .i_wdata(i_wdata),
    .i_set(set1),
    .o_flags(flags1),
    .o_new(new1)
  );

  ifec_flag_bank #(
    .IMPL(`IFEC_BANK2_IMPL)
  ) u_bank2 (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_wr(hit(i_addr, `IFEC_OFS_FLAGS2, i_wr)),
    .i_wdata(i_wdata),
    .i_set(set2),
    .o_flags(flags2),
    .o_new(new2)
  );

  // ****************************************************************
  // Enable registers and request forwarding
  // ****************************************************************
  // Enables share the flag layout; unused positions never store
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable0_r <= 16'h0000;
      enable1_r <= 16'h0000;
      enable2_r <= 16'h0000;
    end else begin
      if (wr_en0) begin
        enable0_r <= i_wdata & `IFEC_BANK0_IMPL; // [R11]
      end
      if (wr_en1) begin
        enable1_r <= i_wdata & `IFEC_BANK1_IMPL; // [R11]
      end
      if (wr_en2) begin
        enable2_r <= i_wdata & `IFEC_BANK2_IMPL; // [R11]
      end
    end
  end

  // A pending flag reaches the CPU only while its enable is set
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_bank0 <= 16'h0000;
      o_req_bank1 <= 16'h0000;
      o_req_bank2 <= 16'h0000;
    end else begin
      o_req_bank0 <= flags0 & enable0_r; // [R11]
      o_req_bank1 <= flags1 & enable1_r; // [R11]
      o_req_bank2 <= flags2 & enable2_r; // [R11]
    end
  end

  // ****************************************************************
  // Interrupt status, mask and output
  // ****************************************************************
  // Sticky events: a newly raised enabled flag per bank, and any
  // external edge; a read clears, an event in that cycle survives
  always @* begin
    irq_status_nxt = rd_status ? 4'h0 : irq_status_r;
    if (|(new0 & enable0_r)) begin
      irq_status_nxt[`IFEC_ST_BANK0] = 1'b1;
    end
    if (|(new1 & enable1_r)) begin
      irq_status_nxt[`IFEC_ST_BANK1] = 1'b1;
    end
    if (|(new2 & enable2_r)) begin
      irq_status_nxt[`IFEC_ST_BANK2] = 1'b1;
    end
    if (|o_ext_edge) begin
      irq_status_nxt[`IFEC_ST_EXT] = 1'b1;
    end
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status_r <= 4'h0;
      irq_mask_r <= 4'h0;
    end else begin
      irq_status_r <= irq_status_nxt;
      if (wr_mask) begin
        irq_mask_r <= i_wdata[3:0] & `IFEC_ST_MASK;
      end
    end
  end

  // Level output, high while any unmasked status bit stands
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(irq_status_nxt & irq_mask_r);
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unimplemented bits and unmapped indices read as zero
  always @* begin
    rdata_nxt = 16'h0000;
    case (i_addr)
      `IFEC_OFS_CTRL2: begin
        rdata_nxt[`IFEC_BIT_ALT_VT] = alt_vt_r; // [R1]
        rdata_nxt[`IFEC_BIT_TIMED_DIS] = timed_dis_r; // [R2]
        rdata_nxt[`IFEC_POL_MSB:`IFEC_POL_LSB] = pol_r; // [R4]
      end
      `IFEC_OFS_FLAGS0: begin
        rdata_nxt = flags0; // [R5]
      end
      `IFEC_OFS_FLAGS1: begin
        rdata_nxt = flags1; // [R5]
      end
      `IFEC_OFS_FLAGS2: begin
        rdata_nxt = flags2; // [R5]
      end
      `IFEC_OFS_ENABLE0: begin
        rdata_nxt = enable0_r;
      end
      `IFEC_OFS_ENABLE1: begin
        rdata_nxt = enable1_r;
      end
      `IFEC_OFS_ENABLE2: begin
        rdata_nxt = enable2_r;
      end
      `IFEC_OFS_IRQ_STATUS: begin
        rdata_nxt[3:0] = irq_status_r;
      end
      `IFEC_OFS_IRQ_MASK: begin
        rdata_nxt[3:0] = irq_mask_r;
      end
      default: begin
        rdata_nxt = 16'h0000;
      end
    endcase
  end

  // Read data stand for one cycle after the strobe, else zero
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rdata_nxt : 16'h0000;
    end
  end

endmodule

// File: include/ifec_consts.vh
// Purpose: Constants for the interrupt flag and edge control block
// Assumes: 16-bit registers reached by word index on a plain port
// Notes:   Masks mark implemented bits; all others read as zero
`ifndef IFEC_CONSTS_VH
`define IFEC_CONSTS_VH

// ****************************************************************
// Register word indices
// ****************************************************************
`define IFEC_ADDR_W 4
`define IFEC_DATA_W 16
`define IFEC_OFS_CTRL2 4'h0
`define IFEC_OFS_FLAGS0 4'h1
`define IFEC_OFS_FLAGS1 4'h2
`define IFEC_OFS_FLAGS2 4'h3
`define IFEC_OFS_ENABLE0 4'h4
`define IFEC_OFS_ENABLE1 4'h5
`define IFEC_OFS_ENABLE2 4'h6
`define IFEC_OFS_IRQ_STATUS 4'h7
`define IFEC_OFS_IRQ_MASK 4'h8

// ****************************************************************
// Field positions
// ****************************************************************
`define IFEC_BIT_ALT_VT 15
`define IFEC_BIT_TIMED_DIS 14
`define IFEC_POL_LSB 0
`define IFEC_POL_MSB 4
`define IFEC_NUM_EXT 5
`define IFEC_BIT_EXT0_FLAG 0
`define IFEC_BIT_EXT1_FLAG 4
`define IFEC_BIT_EXT2_FLAG 13
`define IFEC_ST_BANK0 0
`define IFEC_ST_BANK1 1
`define IFEC_ST_BANK2 2
`define IFEC_ST_EXT 3
`define IFEC_ST_W 4

// ****************************************************************
// Implemented-bit masks and reset values
// ****************************************************************
`define IFEC_CTRL2_WMASK 16'h801f
`define IFEC_BANK0_IMPL 16'h3fef
`define IFEC_BANK1_IMPL 16'hfedf
`define IFEC_BANK2_IMPL 16'h3fe3
`define IFEC_RESET_VAL 16'h0000
`define IFEC_ST_MASK 4'hf

`endif

// File: hw/ifec_flag_bank.v
// Purpose: One bank of sixteen request flags, hardware set, software rw
// Assumes: Write and set inputs are synchronous to i_clk_sys
// Notes:   Bits outside IMPL never store and always read zero
`timescale 1ns/100ps
`include "ifec_consts.vh"

module ifec_flag_bank #(
  parameter [15:0] IMPL = 16'hffff
) (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_wr,
  input wire [15:0] i_wdata,
  input wire [15:0] i_set,
  output reg [15:0] o_flags,
  output reg [15:0] o_new
);

  // ****************************************************************
  // Next flag value
  // ****************************************************************
  reg [15:0] flags_nxt;

  // Software write replaces the value, a write of 1 sets the flag;
  // a hardware set in the same cycle always wins over a cleared bit
  always @* begin
    if (i_wr) begin
      flags_nxt = (i_wdata | i_set) & IMPL; // [R5] [R12]
    end else begin
      flags_nxt = (o_flags | i_set) & IMPL; // [R5] [R10]
    end
  end

  // ****************************************************************
  // Flag storage
  // ****************************************************************
  // Power-on value is zero for every bit
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flags <= `IFEC_RESET_VAL; // [R4]
      o_new <= `IFEC_RESET_VAL;
    end else begin
      o_flags <= flags_nxt;
      o_new <= flags_nxt & ~o_flags; // Rising flags this cycle
    end
  end

endmodule

// File: tb/ifec_top_asserts.sv
// Purpose: Concurrent checks on the flag and edge control ports
// Assumes: One clock, asynchronous active-low reset
// Notes:   Shadows polarity, enable0 bit3 and mask from bus writes
`timescale 1ns/100ps
module ifec_top_asserts (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire [3:0] i_addr,
  input wire [15:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [15:0] o_rdata,
  input wire i_timed_irq_disable_active,
  input wire [4:0] i_ext_pin,
  input wire i_timer1,
  input wire o_alt_vector_table_select,
  input wire [4:0] o_ext_edge,
  input wire [15:0] o_req_bank0,
  input wire o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  reg [4:0] pol_r;
  reg en_r;
  reg [3:0] mask_r;
  // ****************************************
  // Shadow registers
  // ****************************************
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pol_r <= 5'h00;
      en_r <= 1'b0;
      mask_r <= 4'h0;
    end else if (i_wr) begin
      if (i_addr == 4'h0) pol_r <= i_wdata[4:0];
      if (i_addr == 4'h4) en_r <= i_wdata[3];
      if (i_addr == 4'h8) mask_r <= i_wdata[3:0];
    end
  end
  // Selected edge on pin 0
  sequence s_pin0_sel;
    (!i_ext_pin[0] ##1 (i_ext_pin[0] && !pol_r[0])) or
    (i_ext_pin[0] ##1 (!i_ext_pin[0] && pol_r[0]));
  endsequence
  sequence s_ctrl2_rd;
    $past(i_rd) && $past(i_addr) == 4'h0;
  endsequence
  AST_RD_IDLE_ZERO: assert property (
    !$past(i_rd) |-> o_rdata == 16'h0000) else $error("rdata not idle");
  AST_CTRL2_UNIMPL: assert property (
    s_ctrl2_rd |-> o_rdata[13:5] == 9'h000) else $error("ctrl2 spare set");
  AST_TIMED_DIS_STATUS: assert property (
    s_ctrl2_rd |-> o_rdata[14] == $past(i_timed_irq_disable_active, 2))
    else $error("disable status wrong");
  AST_ALT_FOLLOWS: assert property (
    i_wr && i_addr == 4'h0 |=>
    o_alt_vector_table_select == $past(i_wdata[15]))
    else $error("alt table select wrong");
  AST_PIN0_EDGE: assert property (
    s_pin0_sel |-> ##[1:2] o_ext_edge[0]) else $error("pin0 edge missed");
  AST_REQ_GATED: assert property (
    !en_r && !$past(en_r) |-> !o_req_bank0[3]) else $error("req not gated");
  AST_TIMER1_FWD: assert property (
    en_r && i_timer1 |-> ##2 o_req_bank0[3]) else $error("timer1 req lost");
  AST_MASKED_QUIET: assert property (
    mask_r == 4'h0 && $past(mask_r) == 4'h0 |-> !o_irq)
    else $error("irq while masked");
  AST_PIN_IRQ: assert property (
    o_ext_edge[0] && mask_r[3] |=> o_irq) else $error("pin irq missed");
endmodule
bind ifec_top ifec_top_asserts chk_u (.i_clk_sys(i_clk_sys),
  .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata),
  .i_timed_irq_disable_active(i_timed_irq_disable_active),
  .i_ext_pin(i_ext_pin), .i_timer1(i_timer1),
  .o_alt_vector_table_select(o_alt_vector_table_select),
  .o_ext_edge(o_ext_edge), .o_req_bank0(o_req_bank0), .o_irq(o_irq));

// File: tb/ifec_src_model.sv
// Purpose: Peripheral request sources and external pins
// Assumes: Driven by the bench through tasks
// Notes:   Requests are one-cycle pulses; pins are levels
`timescale 1ns/100ps
module ifec_src_model (
  input wire i_clk_sys,
  output logic [47:0] o_req,
  output logic [4:0] o_pin
);
  // ****************************************
  // Source drivers
  // ****************************************
  initial begin
    o_req = 48'h0;
    o_pin = 5'h00;
  end
  // One-cycle request on source i, bank-aligned index
  task fire(input int i);
    @(posedge i_clk_sys);
    o_req[i] <= 1'b1;
    @(posedge i_clk_sys);
    o_req[i] <= 1'b0;
  endtask
  // Pin levels change just after an edge
  task pins(input logic [4:0] v);
    @(posedge i_clk_sys);
    o_pin <= v;
  endtask
endmodule

// File: tb/tb_interrupt_flag_and_edge_control.sv
// Purpose: Register-level bench for the flag and edge control block
// Assumes: Read data stands in the cycle after the strobe
// Notes:   Source index is 16 times bank plus bit position
`timescale 1ns/100ps
module tb_interrupt_flag_and_edge_control;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic dis = 1'b0;
  logic [15:0] o_rdata;
  logic [15:0] rb0;
  logic [15:0] rb1;
  logic [15:0] rb2;
  logic [4:0] ext_edge;
  logic [4:0] edge_log = 5'h00;
  logic o_alt;
  logic o_irq;
  logic [47:0] r;
  logic [4:0] pin;
  logic [47:0] impl = 48'h3fe3_fedf_3fef;
  logic [47:0] srcs = 48'h3fe3_decf_3fee;
  logic [5:0] j;
  int mismatches = 0;
  int check_count = 0;
  always #50 i_clk_sys = ~i_clk_sys;
  // Collects every external edge pulse seen out of reset
  always @(posedge i_clk_sys) begin
    if (i_rst_n) edge_log <= edge_log | ext_edge;
  end
  ifec_src_model src_u (.i_clk_sys(i_clk_sys), .o_req(r), .o_pin(pin));
  ifec_top dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_timed_irq_disable_active(dis), .i_ext_pin(pin),
    .i_adc_done(r[13]), .i_uart1_tx(r[12]), .i_uart1_rx(r[11]),
    .i_spi1_event(r[10]), .i_spi1_fault(r[9]), .i_timer3(r[8]),
    .i_timer2(r[7]), .i_compare2(r[6]), .i_capture2(r[5]),
    .i_timer1(r[3]), .i_compare1(r[2]), .i_capture1(r[1]),
    .i_uart2_tx(r[31]), .i_uart2_rx(r[30]), .i_timer5(r[28]),
    .i_timer4(r[27]), .i_compare4(r[26]), .i_compare3(r[25]),
    .i_capture8(r[23]), .i_capture7(r[22]), .i_change_notify(r[19]),
    .i_comparator(r[18]), .i_i2c1_master(r[17]), .i_i2c1_slave(r[16]),
    .i_parallel_port(r[45]), .i_compare8_5(r[44:41]),
    .i_capture6_3(r[40:37]), .i_spi2_event(r[33]), .i_spi2_fault(r[32]),
    .o_alt_vector_table_select(o_alt), .o_ext_edge(ext_edge),
    .o_req_bank0(rb0), .o_req_bank1(rb1), .o_req_bank2(rb2),
    .o_irq(o_irq));
  // ****************************************
  // Bus and check tasks
  // ****************************************
  task chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk_sys);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    mismatches++;
    $display("BAD t=%0t timeout", $time);
    test_done;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (20) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    for (int a = 0; a < 4; a++) rd(a[3:0], 16'h0000);
    rd(4'hf, 16'h0000);
    $display("test reset done");
    wr(4'h0, 16'hffff);
    chk({15'h0, o_alt}, 16'h0001);
    rd(4'h0, 16'h801f);
    @(posedge i_clk_sys);
    dis <= 1'b1;
    rd(4'h0, 16'hc01f);
    @(posedge i_clk_sys);
    dis <= 1'b0;
    wr(4'h0, 16'h0000);
    chk({15'h0, o_alt}, 16'h0000);
    rd(4'h0, 16'h0000);
    $display("test control done");
    for (int k = 0; k < 3; k++) begin
      wr(k[3:0] + 4'h1, 16'hffff);
      rd(k[3:0] + 4'h1, impl[16*k +: 16]);
      wr(k[3:0] + 4'h1, 16'h0000);
      rd(k[3:0] + 4'h1, 16'h0000);
    end
    $display("test banks done");
    for (int i = 0; i < 48; i++) begin
      j = i[5:0];
      if (srcs[i]) begin
        src_u.fire(i);
        rd({2'b00, j[5:4]} + 4'h1, 16'h0001 << j[3:0]);
        wr({2'b00, j[5:4]} + 4'h1, 16'h0000);
        rd({2'b00, j[5:4]} + 4'h1, 16'h0000);
      end
    end
    $display("test sources done");
    fork
      src_u.fire(3);
      wr(4'h1, 16'h0000);
    join
    rd(4'h1, 16'h0008);
    wr(4'h1, 16'h0000);
    $display("test set wins done");
    wr(4'h8, 16'h000f);
    wr(4'h0, 16'h0002);
    src_u.pins(5'b00010);
    wait_n(3);
    rd(4'h2, 16'h0000);
    src_u.pins(5'b00101);
    wait_n(3);
    rd(4'h1, 16'h0001);
    rd(4'h2, 16'h2010);
    chk({11'h0, edge_log}, 16'h0007);
    chk({15'h0, o_irq}, 16'h0001);
    rd(4'h7, 16'h0008);
    wait_n(2);
    chk({15'h0, o_irq}, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h0000);
    src_u.pins(5'b00000);
    wait_n(3);
    rd(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(4'h0, 16'h0010);
    src_u.pins(5'b11000);
    wait_n(3);
    chk({11'h0, edge_log}, 16'h000f);
    rd(4'h7, 16'h0008);
    src_u.pins(5'b00000);
    wait_n(3);
    chk({11'h0, edge_log}, 16'h001f);
    rd(4'h7, 16'h0008);
    $display("test pins done");
    wr(4'h4, 16'h0008);
    src_u.fire(3);
    wait_n(2);
    chk({15'h0, o_irq}, 16'h0001);
    chk(rb0, 16'h0008);
    rd(4'h7, 16'h0001);
    rd(4'h7, 16'h0000);
    wr(4'h1, 16'h0000);
    wr(4'h8, 16'h0000);
    src_u.fire(3);
    src_u.fire(2);
    wait_n(3);
    chk({15'h0, o_irq}, 16'h0000);
    chk(rb0, 16'h0008);
    wr(4'h5, 16'hffff);
    wr(4'h6, 16'hffff);
    rd(4'h5, 16'hfedf);
    src_u.fire(16);
    src_u.fire(32);
    wait_n(2);
    chk(rb1, 16'h0001);
    chk(rb2, 16'h0001);
    rd(4'h7, 16'h0007);
    $display("test enables done");
    @(posedge i_clk_sys);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(4'h0, 16'h0000);
    rd(4'h1, 16'h0000);
    chk(rb0, 16'h0000);
    $display("test reset again done");
    test_done;
  end
endmodule
